/* src/socket_cfg_defines.vh */
// Constants for the add-in socket configuration decoder.
// Included by the decoder; holds only definitions.
`ifndef SOCKET_CFG_DEFINES_VH
`define SOCKET_CFG_DEFINES_VH

// APB register byte offsets
`define REG_STATUS 12'h000
`define REG_CONTROL 12'h004
`define REG_SSD_STATUS 12'h008
`define REG_DEBOUNCE 12'h00c

// Module type codes
`define TYPE_SSD_SATA 3'h0
`define TYPE_SSD_PCIE 3'h1
`define TYPE_WWAN_PCIE 3'h2
`define TYPE_WWAN_USB3 3'h3
`define TYPE_WWAN_SSIC 3'h4
`define TYPE_RESERVED 3'h5
`define TYPE_EMPTY 3'h6

// Status register field positions
`define ST_TYPE_LSB 0
`define ST_VARIANT_LSB 4
`define ST_VARIANT_NA 6
`define ST_USB2_EN 7
`define ST_HSIC_EN 8
`define ST_VALID 9
`define ST_RAW_LSB 12

// Control register fields and reset value
`define CTL_ROUTE_EN 0
`define CTL_RESET 32'h0000_0001

// Debounce and suspend clock timing
`define DEBOUNCE_US 1000
`define CLK_MHZ 200
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLK_MHZ)
`define SLOW_SUSPEND_CLOCK_HZ 32768
`define CLK_HZ 200000000
`define SLOW_SUSPEND_CLOCK_HALF (`CLK_HZ / (2 * `SLOW_SUSPEND_CLOCK_HZ))

`endif

/* src/socket_config_decode.v */
// Socket configuration decoder: senses the four module configuration lines
// and the SSD socket interface detect pin, decodes type and port variant,
// drives routing selects and a slow suspend clock. APB slave for status.
// Assumes pull-ups on all sense pins at board level; pins are asynchronous.
`timescale 1ns/1ps
`include "socket_cfg_defines.vh"

module socket_config_decode #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter SLOW_SUSPEND_CLOCK_HALF = `SLOW_SUSPEND_CLOCK_HALF
)
(
  input wire clk,
  input wire rst_n,
  input wire [3:0] config_sense,
  input wire ssd_iface_detect,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [2:0] module_type,
  output reg [1:0] port_variant,
  output reg variant_na,
  output reg usb2_enable,
  output reg hsic_enable,
  output reg [1:0] socket_config_pins_mode,
  output reg [2:0] host_mux_sel,
  output reg ssd_pcie_x4,
  output reg decode_valid,
  output reg slow_suspend_clock
);

  reg [4:0] last_in;
  reg [31:0] stable_cnt;
  reg [31:0] debounce_limit;
  reg [4:0] accepted;
  reg route_en;
  reg [15:0] sus_cnt;

  // Decode of bits listed 0..3 into {type, variant}
  function [4:0] decode_cfg;
    input [3:0] b;
    begin
      case ({b[0], b[1], b[2], b[3]})
        4'h0: decode_cfg = {`TYPE_SSD_SATA, 2'h0};
        4'h4: decode_cfg = {`TYPE_SSD_PCIE, 2'h0};
        4'h2: decode_cfg = {`TYPE_WWAN_PCIE, 2'h0};
        4'h6: decode_cfg = {`TYPE_WWAN_PCIE, 2'h1};
        4'h9: decode_cfg = {`TYPE_WWAN_PCIE, 2'h2};
        4'hd: decode_cfg = {`TYPE_WWAN_PCIE, 2'h3};
        4'h1: decode_cfg = {`TYPE_WWAN_USB3, 2'h0};
        4'h5: decode_cfg = {`TYPE_WWAN_USB3, 2'h1};
        4'h3: decode_cfg = {`TYPE_WWAN_USB3, 2'h2};
        4'h7: decode_cfg = {`TYPE_WWAN_USB3, 2'h3};
        4'h8: decode_cfg = {`TYPE_WWAN_SSIC, 2'h0};
        4'hc: decode_cfg = {`TYPE_WWAN_SSIC, 2'h1};
        4'ha: decode_cfg = {`TYPE_WWAN_SSIC, 2'h2};
        4'he: decode_cfg = {`TYPE_WWAN_SSIC, 2'h3};
        4'hb: decode_cfg = {`TYPE_RESERVED, 2'h0};
        default: decode_cfg = {`TYPE_EMPTY, 2'h0};
      endcase
    end
  endfunction

  function is_wwan;
    input [2:0] t;
    begin
      is_wwan = (t == `TYPE_WWAN_PCIE) || (t == `TYPE_WWAN_USB3) || (t == `TYPE_WWAN_SSIC);
    end
  endfunction

  // One-hot register select; reads and writes share the same decode
  function [3:0] reg_hit;
    input [11:0] a;
    begin
      case (a)
        `REG_STATUS: reg_hit = 4'h1;
        `REG_CONTROL: reg_hit = 4'h2;
        `REG_SSD_STATUS: reg_hit = 4'h4;
        `REG_DEBOUNCE: reg_hit = 4'h8;
        default: reg_hit = 4'h0;
      endcase
    end
  endfunction

  // Pin order: detect above the four sense lines
  wire [4:0] pin_in = {ssd_iface_detect, config_sense};
  wire [4:0] cur_in;
  wire [3:0] hit = reg_hit(paddr);
  wire [4:0] dec = decode_cfg(accepted[3:0]);
  wire [2:0] dec_type = dec[4:2];
  wire [1:0] dec_var = dec[1:0];
  wire dec_wwan = is_wwan(dec_type);
  wire apb_access = psel && penable;
  reg [31:0] next_prdata;
  reg next_pslverr;

  // Two-flop synchroniser per pin; open lines read one via board pull-ups
  // Reset to one so an empty socket shows no false change after reset
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_pin_sync
      reg meta;
      reg sync;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta <= 1'b1;
          sync <= 1'b1;
        end
        else
        begin
          meta <= pin_in[gi];
          sync <= meta;
        end
      end
      assign cur_in[gi] = sync;
    end
  endgenerate

  // Debounce: a change restarts the count; module holds straps steady
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_in <= 5'h1f;
      stable_cnt <= 32'h0;
      accepted <= 5'h1f;
      decode_valid <= 1'b0;
    end
    else
    begin
      last_in <= cur_in;
      if (cur_in != last_in)
      begin
        stable_cnt <= 32'h0;
        decode_valid <= 1'b0;
      end
      else if (stable_cnt >= debounce_limit)
      begin
        accepted <= cur_in;
        decode_valid <= 1'b1;
      end
      else
        stable_cnt <= stable_cnt + 32'h1;
    end
  end

  // Routing outputs follow the accepted decode
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      module_type <= `TYPE_EMPTY;
      port_variant <= 2'h0;
      variant_na <= 1'b1;
      usb2_enable <= 1'b0;
      hsic_enable <= 1'b0;
      socket_config_pins_mode <= 2'h0;
      host_mux_sel <= `TYPE_EMPTY;
      ssd_pcie_x4 <= 1'b0;
    end
    else
    begin
      module_type <= dec_type;
      port_variant <= dec_wwan ? dec_var : 2'h0;
      variant_na <= !dec_wwan;
      usb2_enable <= dec_wwan && route_en;
      hsic_enable <= dec_wwan && route_en && (dec_var == 2'h3);
      socket_config_pins_mode <= dec_wwan ? dec_var : 2'h0;
      // Mux parks on empty while routing is disabled or the decode is not valid
      host_mux_sel <= (route_en && decode_valid) ? dec_type : `TYPE_EMPTY;
      ssd_pcie_x4 <= accepted[4];
    end
  end

  // 32 kHz suspend clock by division; divided rate is about 32.776 kHz against 32.768 kHz nominal
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sus_cnt <= 16'h0;
      slow_suspend_clock <= 1'b0;
    end
    else if (sus_cnt >= SLOW_SUSPEND_CLOCK_HALF[15:0] - 16'h1)
    begin
      sus_cnt <= 16'h0;
      slow_suspend_clock <= !slow_suspend_clock;
    end
    else
      sus_cnt <= sus_cnt + 16'h1;
  end

  // APB read mux; unmapped addresses answer with an error
  always @*
  begin
    next_prdata = 32'h0;
    next_pslverr = (hit == 4'h0);
    if (hit[0])
    begin
      next_prdata[`ST_TYPE_LSB +: 3] = dec_type;
      next_prdata[`ST_VARIANT_LSB +: 2] = dec_wwan ? dec_var : 2'h0;
      next_prdata[`ST_VARIANT_NA] = !dec_wwan;
      next_prdata[`ST_USB2_EN] = usb2_enable;
      next_prdata[`ST_HSIC_EN] = hsic_enable;
      next_prdata[`ST_VALID] = decode_valid;
      next_prdata[`ST_RAW_LSB +: 4] = accepted[3:0];
    end
    if (hit[1])
      next_prdata[`CTL_ROUTE_EN] = route_en;
    if (hit[2])
      next_prdata[0] = accepted[4];
    if (hit[3])
      next_prdata = debounce_limit;
  end

  // Zero-wait APB slave: pready high in every access phase
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_pslverr;
      // Captured in setup, so read data stands through the access phase
      if (psel && !penable && !pwrite)
        prdata <= next_prdata;
    end
  end

  // Writes land on the access edge; the limit resets to the full count
  // so no decode is accepted before a whole interval has passed
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_en <= 1'b1;
      debounce_limit <= DEBOUNCE_CYCLES[31:0];
    end
    else if (apb_access && pready && pwrite)
    begin
      if (hit[1])
        route_en <= pwdata[`CTL_ROUTE_EN];
      if (hit[3])
        debounce_limit <= pwdata;
    end
  end

endmodule // socket_config_decode

/* bench/socket_config_decode_checker.sv */
// Output checker for the socket decoder.
// Bound to the decoder top; sees its ports only.
`timescale 1ns/1ps
module socket_config_decode_checker #(
  parameter SLOW_SUSPEND_CLOCK_HALF = 3051
)
(
  input wire clk,
  input wire rst_n,
  input wire [3:0] config_sense,
  input wire [2:0] module_type,
  input wire [1:0] port_variant,
  input wire variant_na,
  input wire usb2_enable,
  input wire hsic_enable,
  input wire [1:0] socket_config_pins_mode,
  input wire [2:0] host_mux_sel,
  input wire decode_valid,
  input wire slow_suspend_clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [15:0] gap;
  reg seen;
  wire wwan = module_type > 3'h1 && module_type < 3'h5;
  sequence s_settle;
    !decode_valid [*5];
  endsequence
  // First toggle after reset has no reference edge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 16'h0;
      seen <= 1'b0;
    end
    else
    begin
      gap <= $changed(slow_suspend_clock) ? 16'h0 : gap + 16'h1;
      seen <= seen | $changed(slow_suspend_clock);
    end
  end
  a_variant_na: assert property (variant_na == !wwan)
    else $error("bad na");
  a_hsic_only: assert property (hsic_enable |-> usb2_enable && port_variant == 2'h3)
    else $error("bad hsic");
  a_usb2_wwan: assert property (usb2_enable |-> wwan)
    else $error("bad usb2");
  a_pin_mode: assert property (socket_config_pins_mode == (wwan ? port_variant : 2'h0))
    else $error("bad mode");
  a_mux_match: assert property ((decode_valid && $stable(module_type)) [*2]
    |-> host_mux_sel inside {3'h6, module_type}) else $error("bad mux");
  a_reset_empty: assert property ($rose(rst_n) |-> module_type == 3'h6 && !decode_valid)
    else $error("bad reset");
  a_change_drop: assert property ($changed(config_sense) |-> ##5 s_settle)
    else $error("bad debounce");
  a_slow_suspend_clock_half: assert property (seen && $changed(slow_suspend_clock) |-> gap == SLOW_SUSPEND_CLOCK_HALF - 1)
    else $error("bad slow_suspend_clock");
endmodule // socket_config_decode_checker
bind socket_config_decode socket_config_decode_checker #(.SLOW_SUSPEND_CLOCK_HALF(SLOW_SUSPEND_CLOCK_HALF)) checker_inst (.clk(clk),
  .rst_n(rst_n), .config_sense(config_sense), .module_type(module_type), .port_variant(port_variant),
  .variant_na(variant_na), .usb2_enable(usb2_enable), .hsic_enable(hsic_enable),
  .socket_config_pins_mode(socket_config_pins_mode), .host_mux_sel(host_mux_sel),
  .decode_valid(decode_valid), .slow_suspend_clock(slow_suspend_clock));

/* bench/module_strap_model.sv */
// Add-in module straps: each sense line open or grounded.
// Open lines read high through the board pull-ups.
`timescale 1ns/1ps
module module_strap_model
(
  input wire [3:0] grounded,
  input wire seat,
  input wire det_gnd,
  output wire [3:0] config_sense,
  output wire ssd_iface_detect
);
  // Empty socket leaves every line to its pull-up
  assign config_sense = seat ? ~grounded : 4'hf;
  assign ssd_iface_detect = !(seat && det_gnd);
endmodule // module_strap_model

/* bench/test_socket_config_decode.sv */
// Bench for the socket decoder: strap model, APB reads, table expectations.
// Assumes short debounce and suspend parameters.
`timescale 1ns/1ps
module test_socket_config_decode;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seat = 1'b0, det_gnd = 1'b0;
  logic pready, pslverr, ssd_iface_detect, ssd_pcie_x4, decode_valid, err;
  logic variant_na, usb2_enable, hsic_enable, slow_suspend_clock;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] grounded = 4'h0, config_sense;
  logic [2:0] module_type, host_mux_sel;
  logic [1:0] port_variant, socket_config_pins_mode;
  int fails = 0, check_count = 0, cyc = 0;
  logic [4:0] tbl [16] = '{5'h00, 5'h10, 5'h04, 5'h11, 5'h08, 5'h12, 5'h09, 5'h13,
    5'h0c, 5'h0a, 5'h0d, 5'h0b, 5'h0e, 5'h14, 5'h0f, 5'h18};
  wire [12:0] got = {module_type, port_variant, variant_na, usb2_enable, hsic_enable,
    socket_config_pins_mode, host_mux_sel};
  always #2.5 clk = ~clk;
  module_strap_model module_strap_model_inst (.grounded(grounded), .seat(seat), .det_gnd(det_gnd),
    .config_sense(config_sense), .ssd_iface_detect(ssd_iface_detect));
  socket_config_decode #(.DEBOUNCE_CYCLES(8), .SLOW_SUSPEND_CLOCK_HALF(20)) socket_config_decode_inst (.clk(clk), .rst_n(rst_n),
    .config_sense(config_sense), .ssd_iface_detect(ssd_iface_detect), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_type(module_type), .port_variant(port_variant), .variant_na(variant_na), .usb2_enable(usb2_enable),
    .hsic_enable(hsic_enable), .socket_config_pins_mode(socket_config_pins_mode), .host_mux_sel(host_mux_sel),
    .ssd_pcie_x4(ssd_pcie_x4), .decode_valid(decode_valid), .slow_suspend_clock(slow_suspend_clock));
  function automatic logic [12:0] exp_out(input logic [3:0] s, input logic on);
    logic w;
    w = tbl[s][4:2] inside {3'h2, 3'h3, 3'h4};
    return {tbl[s], !w, w & on, w & on & (tbl[s][1:0] == 2'h3), tbl[s][1:0], on ? tbl[s][4:2] : 3'h6};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, generous against about nine hundred cycles of tests
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    logic [3:0] s;
    logic [3:0] p;
    logic [12:0] x;
    void'($urandom(32'hde86));
    p = 4'hf;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("empty", 32'h6, module_type);
    chk("not valid", 32'h0, decode_valid);
    apb(1'b0, 12'h004, 32'h0);
    chk("control", 32'h1, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("limit reset", 32'h8, rd);
    apb(1'b1, 12'h00c, 32'ha);
    apb(1'b0, 12'h00c, 32'h0);
    chk("limit write", 32'ha, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      s = i < 16 ? i[3:0] : 4'($urandom);
      s = s == p ? s ^ 4'h1 : s;
      grounded <= ~s;
      seat <= s != 4'hf || i[0];
      p = s;
      repeat (4) @(posedge clk);
      chk("dropped", 32'h0, decode_valid);
      while (decode_valid !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      x = exp_out(s, 1'b1);
      chk("outputs", {19'h0, x}, {19'h0, got});
      apb(1'b0, 12'h000, 32'h0);
      chk("status", {16'h0, s, 3'h1, x[5], x[6], x[7], x[9:8], 1'b0, x[12:10]}, rd);
      if (i == 11)
      begin
        apb(1'b1, 12'h004, 32'h0);
        repeat (2) @(posedge clk);
        chk("no route", {19'h0, exp_out(s, 1'b0)}, {19'h0, got});
        apb(1'b1, 12'h004, 32'h1);
        repeat (2) @(posedge clk);
      end
    end
    $display("test decode done");
    repeat (12)
    begin
      grounded <= grounded ^ 4'h2;
      repeat (3) @(posedge clk);
    end
    chk("bouncing", 32'h0, decode_valid);
    $display("test bounce done");
    for (int d = 0; d < 2; d++)
    begin
      det_gnd <= d[0];
      repeat (20) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0);
      chk("detect", {30'h0, !d[0], !d[0]}, {rd[30:0], ssd_pcie_x4});
    end
    $display("test detect done");
    wrap_up();
  end
endmodule // test_socket_config_decode
